// ===== adc_ctrl_pkg.sv
/*
  shared constants and carrier types for the dual channel converter control.
  assumes a 125 MHz core clock.
*/
package adc_ctrl_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned CONV_TIME_NS    = 800;
  localparam int unsigned CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_HALF       = CONV_CYCLES / 2;
  localparam int unsigned ACQ_TIME_NS     = 200;
  localparam int unsigned ACQ_CYCLES      = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SCLK_DIV        = 4;
  localparam int unsigned SER_BITS        = 32;
  localparam int unsigned RES_BITS        = 16;
  localparam logic [15:0] RESULT_RST      = 16'h0000;
  localparam int unsigned FIFO_DEPTH      = 16;

  typedef struct packed {
    logic [15:0] chan_a;
    logic [15:0] chan_b;
  } result_pair_t;

  typedef struct packed {
    logic [15:0] data_out;
    logic [15:0] data_oe;
  } bus_drive_t;
endpackage

// ===== result_fifo.sv
/*
  small synchronous fifo for conversion result pairs.
  assumes a single clock domain shared by writer and reader.
*/
`timescale 1ns/1ps
module result_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
  logic             push, pop;

  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  assign in_ready  = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
  assign out_valid = (wr_reg != rd_reg);
  assign out_data  = mem[rd_reg[AW-1:0]];
endmodule

// ===== adc_conv_readout.sv
/*
  conversion sequencing and parallel/serial result read-out of a two channel converter.
  assumes host strobes and link clock are asynchronous and pass synchronisers here;
  analog results arrive as ready words on sar_a and sar_b.
*/
`timescale 1ns/1ps
module adc_conv_readout (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // conversion control pins
  input  wire logic        convert_strobe_n,
  input  wire logic        power_down_input,
  input  wire logic        input_pair_select,
  input  wire logic        low_power_mode,
  // interface control pins
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        chan_select,
  input  wire logic        serial_parallel_select,
  input  wire logic        byte_order_exchange,
  input  wire logic        clock_source_select,
  input  wire logic        sclk_in,
  // converter core results
  input  wire logic [15:0] sar_a,
  input  wire logic [15:0] sar_b,
  // analog side controls
  output logic             mux_input_first,
  output logic             mux_input_second,
  output logic             analog_power_en,
  output logic             busy,
  output logic             eoc_a,
  // data bus and serial pins
  output logic [15:0]      data_out,
  output logic [15:0]      data_oe,
  output logic             serial_result_output,
  output logic             serial_result_oe,
  output logic             sclk_out,
  output logic             sclk_oe
);
  // ==========================================================
  // input synchronisers
  logic [1:0] cnv_s, cs_s, rd_s, sck_s;
  logic       sck_prev_reg;
  logic       cnv_low, cs_low, rd_low, sck_rise;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnv_s        <= 2'h3;
      cs_s         <= 2'h3;
      rd_s         <= 2'h3;
      sck_s        <= 2'h0;
      sck_prev_reg <= 1'b0;
    end else begin
      cnv_s        <= {cnv_s[0], convert_strobe_n};
      cs_s         <= {cs_s[0], cs_n};
      rd_s         <= {rd_s[0], rd_n};
      sck_s        <= {sck_s[0], sclk_in};
      sck_prev_reg <= sck_s[1];
    end
  end

  always_comb begin
    cnv_low  = !cnv_s[1];
    cs_low   = !cs_s[1];
    rd_low   = !rd_s[1];
    sck_rise = sck_s[1] && !sck_prev_reg;
  end

  // ==========================================================
  // conversion sequencer
  typedef enum logic [1:0] {S_IDLE, S_CONV_A, S_CONV_B, S_ACQ} conv_state_t;
  conv_state_t  state_reg, state_next;
  logic [7:0]   cnt_reg, cnt_next;
  logic         cnv_prev_reg, cnv_prev_next;
  logic         busy_reg, busy_next, eoc_reg, eoc_next;
  logic         pwr_reg, pwr_next;
  logic         pair_reg, pair_next, pair_n_reg;
  logic [15:0]  res_a_reg, res_a_next, res_b_reg, res_b_next;
  logic         pair_done;
  logic         start;

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    cnv_prev_next = cnv_low;
    busy_next     = busy_reg;
    eoc_next      = eoc_reg;
    pwr_next      = pwr_reg;
    pair_next     = pair_reg;
    res_a_next    = res_a_reg;
    res_b_next    = res_b_reg;
    pair_done     = 1'b0;
    // falling strobe edge, independent of cs_n and rd_n
    start = cnv_low && !cnv_prev_reg;
    unique case (state_reg)
      S_IDLE: begin
        pair_next = input_pair_select;
        if (start && !power_down_input) begin
          state_next = S_CONV_A;
          cnt_next   = 8'(adc_ctrl_pkg::CONV_HALF);
          busy_next  = 1'b1;
          eoc_next   = 1'b1;
          pwr_next   = 1'b1;
        end
      end
      S_CONV_A: begin
        // strobe and power-down ignored until done
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          res_a_next = sar_a;
          eoc_next   = 1'b0;
          state_next = S_CONV_B;
          cnt_next   = 8'(adc_ctrl_pkg::CONV_CYCLES - adc_ctrl_pkg::CONV_HALF);
        end
      end
      S_CONV_B: begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          res_b_next = sar_b;
          pair_done  = 1'b1;
          busy_next  = 1'b0;
          pwr_next   = !low_power_mode;
          if (low_power_mode && cnv_low) begin
            state_next = S_ACQ;
            cnt_next   = 8'(adc_ctrl_pkg::ACQ_CYCLES);
          end else begin
            state_next = S_IDLE;
          end
        end
      end
      S_ACQ: begin
        pair_next = input_pair_select;
        cnt_next  = cnt_reg - 8'h01;
        if (!cnv_low || power_down_input) begin
          state_next = S_IDLE;
        end else if (cnt_reg == 8'h01) begin
          state_next = S_CONV_A;
          cnt_next   = 8'(adc_ctrl_pkg::CONV_HALF);
          busy_next  = 1'b1;
          eoc_next   = 1'b1;
          pwr_next   = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= S_IDLE;
      cnt_reg      <= 8'h00;
      cnv_prev_reg <= 1'b0;
      busy_reg     <= 1'b0;
      eoc_reg      <= 1'b0;
      pwr_reg      <= 1'b0;
      pair_reg     <= 1'b1;
      pair_n_reg   <= 1'b0;
      res_a_reg    <= adc_ctrl_pkg::RESULT_RST;
      res_b_reg    <= adc_ctrl_pkg::RESULT_RST;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      cnv_prev_reg <= cnv_prev_next;
      busy_reg     <= busy_next;
      eoc_reg      <= eoc_next;
      pwr_reg      <= pwr_next;
      pair_reg     <= pair_next;
      pair_n_reg   <= !pair_next;
      res_a_reg    <= res_a_next;
      res_b_reg    <= res_b_next;
    end
  end

  // ==========================================================
  // result pair fifo towards the serial shifter
  adc_ctrl_pkg::result_pair_t fifo_in, fifo_out;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;

  always_comb begin
    fifo_in.chan_a = res_a_next;
    fifo_in.chan_b = res_b_next;
  end

  result_fifo #(
    .WIDTH (adc_ctrl_pkg::SER_BITS),
    .DEPTH (adc_ctrl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_valid  (pair_done && serial_parallel_select),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // ==========================================================
  // serial shifter and parallel bus driver
  logic [31:0] shift_reg, shift_next;
  logic [5:0]  bits_reg, bits_next;
  logic [2:0]  div_reg, div_next;
  logic        sck_reg, sck_next;
  logic        sck_edge;
  logic        enable;
  adc_ctrl_pkg::bus_drive_t bus_reg, bus_next;
  logic        sdo_reg, sdo_next, sdo_oe_reg, sdo_oe_next, sck_oe_reg, sck_oe_next;
  logic [15:0] word;

  always_comb begin
    enable     = cs_low && rd_low;
    shift_next = shift_reg;
    bits_next  = bits_reg;
    div_next   = div_reg;
    sck_next   = 1'b0;
    fifo_pop   = 1'b0;
    sck_edge   = 1'b0;
    // parallel word, A while channel B still converts
    word = chan_select ? res_a_reg : res_b_reg;
    bus_next.data_out = byte_order_exchange ? {word[7:0], word[15:8]} : word;
    bus_next.data_oe  = (enable && !serial_parallel_select) ? 16'hFFFF : 16'h0000;
    if (serial_parallel_select) begin
      if (bits_reg == 6'h00) begin
        if (fifo_out_valid) begin
          fifo_pop   = 1'b1;
          shift_next = chan_select ? {fifo_out.chan_a, fifo_out.chan_b}
                                   : {fifo_out.chan_b, fifo_out.chan_a};
          bits_next  = 6'(adc_ctrl_pkg::SER_BITS);
        end
      end else if (enable) begin
        if (clock_source_select) begin
          sck_edge = sck_rise;
        end else begin
          div_next = div_reg + 3'h1;
          sck_next = (div_reg >= 3'(adc_ctrl_pkg::SCLK_DIV / 2));
          if (div_reg == 3'(adc_ctrl_pkg::SCLK_DIV - 1)) begin
            div_next = 3'h0;
            sck_edge = 1'b1;
          end
        end
        if (sck_edge) begin
          shift_next = {shift_reg[30:0], 1'b0};
          bits_next  = bits_reg - 6'h01;
        end
      end
    end
    sdo_next    = shift_next[31];
    sdo_oe_next = enable && serial_parallel_select;
    sck_oe_next = enable && serial_parallel_select && !clock_source_select;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg  <= 32'h00000000;
      bits_reg   <= 6'h00;
      div_reg    <= 3'h0;
      sck_reg    <= 1'b0;
      bus_reg    <= '0;
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
      sck_oe_reg <= 1'b0;
    end else begin
      shift_reg  <= shift_next;
      bits_reg   <= bits_next;
      div_reg    <= div_next;
      sck_reg    <= sck_next;
      bus_reg    <= bus_next;
      sdo_reg    <= sdo_next;
      sdo_oe_reg <= sdo_oe_next;
      sck_oe_reg <= sck_oe_next;
    end
  end

  // ==========================================================
  // outputs
  assign mux_input_first      = pair_reg;
  assign mux_input_second     = pair_n_reg;
  assign analog_power_en      = pwr_reg;
  assign busy                 = busy_reg;
  assign eoc_a                = eoc_reg;
  assign data_out             = bus_reg.data_out;
  assign data_oe              = bus_reg.data_oe;
  assign serial_result_output = sdo_reg;
  assign serial_result_oe     = sdo_oe_reg;
  assign sclk_out             = sck_reg;
  assign sclk_oe              = sck_oe_reg;

  // ==========================================================
  // checks
  property p_no_abort;
    @(posedge core_clk) disable iff (!rst_b)
      (state_reg == S_IDLE && state_next == S_CONV_A) |=> busy_reg [*8];
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("conversion aborted early");

  property p_start_cs;
    @(posedge core_clk) disable iff (!rst_b)
      (state_reg == S_IDLE && start && !power_down_input) |=> busy_reg;
  endproperty
  a_start_cs: assert property (p_start_cs) else $error("strobe did not start conversion");

  property p_mux;
    @(posedge core_clk) disable iff (!rst_b)
      mux_input_first != mux_input_second;
  endproperty
  a_mux: assert property (p_mux) else $error("mux selects not exclusive");

  property p_fast_norepeat;
    @(posedge core_clk) disable iff (!rst_b)
      (!low_power_mode && $fell(busy_reg)) |-> state_reg == S_IDLE;
  endproperty
  a_fast_norepeat: assert property (p_fast_norepeat) else $error("fast mode repeated");

  property p_power_cut;
    @(posedge core_clk) disable iff (!rst_b)
      (low_power_mode && $fell(busy_reg)) |-> !pwr_reg;
  endproperty
  a_power_cut: assert property (p_power_cut) else $error("power not cut");

  property p_float;
    @(posedge core_clk) disable iff (!rst_b)
      !$past(enable) |-> (data_oe == 16'h0000 && !serial_result_oe && !sclk_oe);
  endproperty
  a_float: assert property (p_float) else $error("outputs driven while deselected");

  property p_bytes;
    @(posedge core_clk) disable iff (!rst_b)
      ($past(byte_order_exchange) && $past(chan_select)) |-> data_out == {$past(res_a_reg[7:0]), $past(res_a_reg[15:8])};
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte order wrong");

  property p_eoc_a;
    @(posedge core_clk) disable iff (!rst_b)
      $fell(eoc_reg) |-> busy_reg;
  endproperty
  a_eoc_a: assert property (p_eoc_a) else $error("channel a not early");

  property p_load32;
    @(posedge core_clk) disable iff (!rst_b)
      fifo_pop |=> bits_reg == 6'h20;
  endproperty
  a_load32: assert property (p_load32) else $error("serial count wrong");
endmodule

// ===== host_serial_reader.sv
/*
  host side model that reads a 32 bit serial result from the converter, clocking it out on sclk_in only when use_ext is set.
  assumes the bench asserts chip select and read before raising start.
*/
`timescale 1ns/1ps
module host_serial_reader (
  // start and clock source control
  input  wire logic   start,
  input  wire logic   use_ext,
  // serial pins
  input  wire logic   sclk_out,
  input  wire logic   sdo,
  output logic        sclk_in,
  // captured result
  output logic [31:0] word,
  output logic        done
);
  // ==========================================
  // burst reader, clock idles low between frames
  initial begin
    sclk_in = 1'b0;
    word = 32'h0000_0000;
    done = 1'b0;
    forever begin
      @(posedge start);
      done = 1'b0;
      for (int i = 0; i < 32; i++) begin
        if (use_ext) begin
          #62.5;
          word = {word[30:0], sdo};
          sclk_in = 1'b1;
          #62.5;
          sclk_in = 1'b0;
        end else begin
          @(posedge sclk_out);
          word = {word[30:0], sdo};
        end
      end
      done = 1'b1;
    end
  end
endmodule

// ===== tb_top.sv
/*
  self-checking bench for the converter control and read-out block.
  assumes the host reader model and the design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, rst_b, cnv_n, pd, psel, lpm, cs_n, rd_n, chsel, serpar, bswap, csrc, start;
  logic        sclk_in, mux_first, mux_second, pwr_en, busy, eoc_a, sdo, sdo_oe, sclk_out, sclk_oe, done;
  logic [15:0] sar_a, sar_b, data_out, data_oe;
  logic [31:0] word;
  int          fail_count;
  int          comparisons;

  // ==========================================
  // clock, design and host model
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  adc_conv_readout u_adc_conv_readout (.core_clk(core_clk), .rst_b(rst_b), .convert_strobe_n(cnv_n),
    .power_down_input(pd), .input_pair_select(psel), .low_power_mode(lpm), .cs_n(cs_n), .rd_n(rd_n),
    .chan_select(chsel), .serial_parallel_select(serpar), .byte_order_exchange(bswap),
    .clock_source_select(csrc), .sclk_in(sclk_in), .sar_a(sar_a), .sar_b(sar_b),
    .mux_input_first(mux_first), .mux_input_second(mux_second), .analog_power_en(pwr_en), .busy(busy),
    .eoc_a(eoc_a), .data_out(data_out), .data_oe(data_oe), .serial_result_output(sdo),
    .serial_result_oe(sdo_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe));

  host_serial_reader u_host_serial_reader (.start(start), .use_ext(csrc), .sclk_out(sclk_out), .sdo(sdo),
    .sclk_in(sclk_in), .word(word), .done(done));

  // ==========================================
  // shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic convert(input logic hold);
    int n;
    cnv_n = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    if (!hold) cnv_n = 1'b1;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      step(1);
      n++;
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_serial;
    for (int i = 0; i < 2; i++) begin
      serpar = 1'b1;
      chsel = i[0];
      csrc = i[0];
      sar_a = 16'hC35A ^ {16{i[0]}};
      sar_b = 16'h0F81 ^ {16{i[0]}};
      convert(1'b0);
      wait_idle();
      cs_n = 1'b0;
      rd_n = 1'b0;
      step(4);
      chk("serial enable", 1'b1, sdo_oe);
      chk("serial clock enable", !csrc, sclk_oe);
      chk("bus off in serial", 16'h0000, data_oe);
      start = 1'b1;
      step(1);
      for (int n = 0; n < 1000 && done !== 1'b1; n++) step(1);
      start = 1'b0;
      chk("serial word", chsel ? {sar_a, sar_b} : {sar_b, sar_a}, word);
      cs_n = 1'b1;
      rd_n = 1'b1;
      step(4);
      chk("serial float", 1'b0, sdo_oe);
    end
    serpar = 1'b0;
    $display("test serial done");
  endtask

  task automatic t_timing;
    int nb, ne;
    convert(1'b0);
    chk("power on", 1'b1, pwr_en);
    nb = 0;
    ne = 0;
    while (busy === 1'b1 && nb < 300) begin
      if (eoc_a === 1'b1) ne++;
      if (nb == 20) cnv_n = 1'b0;
      if (nb == 20) pd = 1'b1;
      if (nb == 23) cnv_n = 1'b1;
      if (nb == 23) pd = 1'b0;
      step(1);
      nb++;
    end
    chk("busy cycles", adc_ctrl_pkg::CONV_CYCLES, nb);
    chk("eoc cycles", adc_ctrl_pkg::CONV_HALF, ne);
    step(40);
    chk("no restart", 1'b0, busy);
    pd = 1'b1;
    cnv_n = 1'b0;
    step(4);
    cnv_n = 1'b1;
    step(10);
    chk("power down start", 1'b0, busy);
    pd = 1'b0;
    for (int i = 0; i < 2; i++) begin
      psel = i[0];
      step(4);
      chk("mux first", psel, mux_first);
      chk("mux second", !psel, mux_second);
    end
    $display("test timing done");
  endtask

  task automatic t_parallel;
    logic [15:0] w;
    lpm = 1'b1;
    sar_a = 16'hFFFF;
    sar_b = 16'h0000;
    convert(1'b0);
    wait_idle();
    step(5);
    chk("power cut", 1'b0, pwr_en);
    for (int i = 0; i < 4; i++) begin
      chsel = i[0];
      bswap = i[1];
      cs_n = 1'b0;
      rd_n = 1'b0;
      step(5);
      w = chsel ? sar_a : sar_b;
      chk("bus enable", 16'hFFFF, data_oe);
      chk("bus data", bswap ? {w[7:0], w[15:8]} : w, data_out);
      if (i[0]) cs_n = 1'b1;
      else rd_n = 1'b1;
      step(5);
      chk("bus float", 16'h0000, data_oe);
      cs_n = 1'b1;
      rd_n = 1'b1;
      step(1);
    end
    sar_a = 16'h8001;
    sar_b = 16'h7FFE;
    chsel = 1'b1;
    bswap = 1'b0;
    convert(1'b0);
    step(58);
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(5);
    chk("b still busy", 1'b1, busy);
    chk("early a data", 16'h8001, data_out);
    cs_n = 1'b1;
    rd_n = 1'b1;
    wait_idle();
    $display("test parallel done");
  endtask

  task automatic t_repeat;
    int rises;
    logic prev;
    for (int i = 0; i < 2; i++) begin
      lpm = ~i[0];
      rises = 0;
      prev = 1'b0;
      cnv_n = 1'b0;
      for (int n = 0; n < 320; n++) begin
        if (busy === 1'b1 && prev === 1'b0) rises++;
        prev = busy;
        step(1);
      end
      cnv_n = 1'b1;
      wait_idle();
      step(40);
      chk("auto repeat", lpm ? 32'(rises >= 2) : 32'(rises == 1), 32'h1);
    end
    $display("test repeat done");
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    {cnv_n, cs_n, rd_n} = 3'h7;
    {rst_b, pd, psel, lpm, chsel, serpar, bswap, csrc, start} = 9'h000;
    sar_a = 16'h0000;
    sar_b = 16'h0000;
    fail_count = 0;
    comparisons = 0;
    step(16);
    rst_b = 1'b1;
    step(4);
    t_serial();
    t_timing();
    t_parallel();
    t_repeat();
    end_of_test();
  end

  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule
